//--- rtl/stc3_pkg.sv
/*
 * Package of the 16-bit timer/counter: register offsets, control field
 * layout, reset values, special-event code and timing constants.
 * Assumes a 32-bit AHB-Lite register bus and a 10 MHz ref_clk.
 */
package stc3_pkg;

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_COUNT_LOW = 8'h04;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'h08;
	localparam logic [7:0] ADDR_FLAGS = 8'h0c;
	localparam logic [7:0] ADDR_ENABLES = 8'h10;
	localparam int ADDR_BITS = 8;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int FLAG_OVERFLOW_BIT = 0;
	localparam int ENABLE_OVERFLOW_BIT = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_LAST = 16'hffff;
	localparam logic [3:0] SPECIAL_EVENT_CODE = 4'hb;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

	// ----------------------------------------------------------------
	// timing: instruction clock is the system clock divided by four
	// ----------------------------------------------------------------
	localparam int REF_CLK_HZ = 10_000_000;
	localparam int INSTR_DIVIDE = 4;
	localparam logic [1:0] INSTR_PHASE_LAST = 2'(INSTR_DIVIDE - 1);

	// control register, bit 7 down to bit 0
	typedef struct packed {
		logic wide_access_enable;
		logic time_base_select_upper;
		logic [1:0] input_prescale_select;
		logic time_base_select_lower;
		logic external_sync_disable;
		logic clock_source_select;
		logic counter_run;
	} stc3_control_t;

	// one captured AHB address phase
	typedef struct packed {
		logic valid;
		logic write;
		logic [ADDR_BITS-1:0] addr;
	} stc3_bus_phase_t;

	// last prescaler count for each select code: 1:1, 1:2, 1:4, 1:8
	function automatic logic [2:0] stc3_prescale_last(input logic [1:0] sel);
		logic [2:0] last;
		last = 3'h0;
		case (sel)
			2'h0: last = 3'h0;
			2'h1: last = 3'h1;
			2'h2: last = 3'h3;
			2'h3: last = 3'h7;
			default: last = 3'h0;
		endcase
		return last;
	endfunction : stc3_prescale_last

endpackage : stc3_pkg

//--- rtl/stc3_timer.sv
/*
 * 16-bit up-counting timer/counter with prescaler, buffered 16-bit access,
 * overflow flag, special-event reset and capture/compare time-base select.
 * Assumes: AHB-Lite single word transfers with an idle cycle between them,
 * external count pin and oscillator asynchronous to ref_clk.
 */
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps

module stc3_timer (
	input wire logic ref_clk,
	input wire logic rst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// clock inputs from pins
	input wire logic external_count_pin,
	input wire logic low_freq_osc_in,
	input wire logic low_freq_osc_enable,
	output logic [1:0] pin_read_value,
	// capture/compare units
	input wire logic [3:0] first_capcomp_mode,
	input wire logic [3:0] second_capcomp_mode,
	input wire logic first_capcomp_match,
	input wire logic second_capcomp_match,
	output logic first_unit_uses_this_timer,
	output logic second_unit_uses_this_timer,
	// converter and interrupt request
	input wire logic adc_enable,
	output logic adc_start,
	output logic overflow_irq
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	stc3_pkg::stc3_control_t control_reg;
	stc3_pkg::stc3_control_t control_next;
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic [7:0] high_buffer_reg;
	logic [7:0] high_buffer_next;
	logic overflow_flag_reg;
	logic overflow_flag_next;
	logic overflow_irq_enable_reg;
	logic overflow_irq_enable_next;
	logic [2:0] prescale_reg;
	logic [2:0] prescale_next;
	logic [1:0] instr_phase_reg;
	logic sync_pending_reg;
	logic sync_pending_next;
	logic [1:0] pin_meta_reg;
	logic [1:0] pin_sync_reg;
	logic ext_prev_reg;
	logic armed_reg;
	logic [1:0] pin_read_reg;
	logic adc_start_reg;
	stc3_pkg::stc3_bus_phase_t phase_reg;
	logic [31:0] hrdata_reg;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire addr_accept = hsel && htrans[1] && hready;
	wire [stc3_pkg::ADDR_BITS-1:0] addr_now = haddr[stc3_pkg::ADDR_BITS-1:0];
	wire rd_now = addr_accept && !hwrite;
	wire rd_low_now = rd_now && (addr_now == stc3_pkg::ADDR_COUNT_LOW);
	wire wr_phase = phase_reg.valid && phase_reg.write;
	wire wr_control = wr_phase && (phase_reg.addr == stc3_pkg::ADDR_CONTROL);
	wire wr_low = wr_phase && (phase_reg.addr == stc3_pkg::ADDR_COUNT_LOW);
	wire wr_high = wr_phase && (phase_reg.addr == stc3_pkg::ADDR_COUNT_HIGH);
	wire wr_flags = wr_phase && (phase_reg.addr == stc3_pkg::ADDR_FLAGS);
	wire wr_enables = wr_phase && (phase_reg.addr == stc3_pkg::ADDR_ENABLES);
	wire [7:0] wdata_byte = hwdata[7:0];
	wire wide = control_reg.wide_access_enable;

	// high byte as seen by software
	wire [7:0] high_view = wide ? high_buffer_reg : count_reg[15:8];

	logic [31:0] read_mux;
	always_comb begin
		read_mux = stc3_pkg::READ_UNMAPPED;
		case (addr_now)
			stc3_pkg::ADDR_CONTROL: read_mux = {24'h000000, control_reg};
			stc3_pkg::ADDR_COUNT_LOW: read_mux = {24'h000000, count_reg[7:0]};
			stc3_pkg::ADDR_COUNT_HIGH: read_mux = {24'h000000, high_view};
			stc3_pkg::ADDR_FLAGS: read_mux = {31'h00000000, overflow_flag_reg};
			stc3_pkg::ADDR_ENABLES: read_mux = {31'h00000000, overflow_irq_enable_reg};
			default: read_mux = stc3_pkg::READ_UNMAPPED;
		endcase
	end

	// ----------------------------------------------------------------
	// pin synchronisers and pin read path
	// ----------------------------------------------------------------
	wire [1:0] pin_raw = {low_freq_osc_in, external_count_pin};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pin_sync
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					pin_meta_reg[gi] <= 1'b0;
					pin_sync_reg[gi] <= 1'b0;
				end else begin
					pin_meta_reg[gi] <= pin_raw[gi];
					pin_sync_reg[gi] <= pin_meta_reg[gi];
				end
			end
		end
	endgenerate

	// oscillator running: pin logic is cut off and both pins read low
	wire [1:0] pin_read_next = low_freq_osc_enable ? 2'h0 : pin_sync_reg;

	// ----------------------------------------------------------------
	// input clock selection and edge detection
	// ----------------------------------------------------------------
	wire instr_tick = (instr_phase_reg == stc3_pkg::INSTR_PHASE_LAST);
	wire ext_level = low_freq_osc_enable ? pin_sync_reg[1] : pin_sync_reg[0];
	wire ext_fall = ext_prev_reg && !ext_level;
	// rising edges count only once a falling edge has armed the input
	wire ext_rise = !ext_prev_reg && ext_level && armed_reg;
	wire external = control_reg.clock_source_select;
	wire unsync = external && control_reg.external_sync_disable;
	wire source_tick = external ? ext_rise : instr_tick;
	wire run = control_reg.counter_run;

	// ----------------------------------------------------------------
	// prescaler
	// ----------------------------------------------------------------
	wire [2:0] prescale_last = stc3_pkg::stc3_prescale_last(control_reg.input_prescale_select);
	wire prescale_wrap = run && source_tick && (prescale_reg >= prescale_last);

	always_comb begin
		prescale_next = prescale_reg;
		if (wr_low) begin
			prescale_next = 3'h0;
		end else if (run && source_tick) begin
			prescale_next = prescale_wrap ? 3'h0 : prescale_reg + 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// count advance
	// ----------------------------------------------------------------
	// synchronised external edges wait for the next instruction cycle
	wire sync_path = external && !unsync;
	wire increment_ext_sync = sync_path && run && instr_tick && (sync_pending_reg || prescale_wrap);
	wire increment_direct = !sync_path && prescale_wrap;
	wire increment = increment_direct || increment_ext_sync;

	always_comb begin
		sync_pending_next = sync_pending_reg;
		if (!sync_path || !run || wr_low) begin
			sync_pending_next = 1'b0;
		end else if (instr_tick) begin
			sync_pending_next = 1'b0;
		end else if (prescale_wrap) begin
			sync_pending_next = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// special event and time-base selection
	// ----------------------------------------------------------------
	assign first_unit_uses_this_timer = control_reg.time_base_select_upper;
	assign second_unit_uses_this_timer = control_reg.time_base_select_upper
		|| control_reg.time_base_select_lower;
	wire first_event = first_capcomp_match && first_unit_uses_this_timer
		&& (first_capcomp_mode == stc3_pkg::SPECIAL_EVENT_CODE);
	wire second_event = second_capcomp_match && second_unit_uses_this_timer
		&& (second_capcomp_mode == stc3_pkg::SPECIAL_EVENT_CODE);
	wire special_reset = first_event || second_event;
	wire adc_start_next = special_reset && adc_enable;

	// ----------------------------------------------------------------
	// count and buffer update
	// ----------------------------------------------------------------
	wire wrap = increment && (count_reg == stc3_pkg::COUNT_LAST);
	wire count_write = wr_low || (wr_high && !wide);

	always_comb begin
		count_next = count_reg;
		if (wr_low) begin
			// write wins over a same-cycle special-event reset
			count_next[7:0] = wdata_byte;
			if (wide) begin
				count_next[15:8] = high_buffer_reg;
			end
		end else if (wr_high && !wide) begin
			count_next[15:8] = wdata_byte;
		end
		if (!count_write && special_reset) begin
			count_next = stc3_pkg::COUNT_RESET;
		end else if (!count_write && increment) begin
			count_next = count_reg + 16'h0001;
		end
	end

	always_comb begin
		high_buffer_next = high_buffer_reg;
		if (wr_high && wide) begin
			high_buffer_next = wdata_byte;
		end else if (rd_low_now && wide) begin
			high_buffer_next = count_reg[15:8];
		end
	end

	// ----------------------------------------------------------------
	// control, flag and enable registers
	// ----------------------------------------------------------------
	assign control_next = wr_control ? stc3_pkg::stc3_control_t'(wdata_byte) : control_reg;
	assign overflow_irq_enable_next = wr_enables
		? hwdata[stc3_pkg::ENABLE_OVERFLOW_BIT] : overflow_irq_enable_reg;

	always_comb begin
		overflow_flag_next = overflow_flag_reg;
		if (wr_flags) begin
			overflow_flag_next = hwdata[stc3_pkg::FLAG_OVERFLOW_BIT];
		end
		// besides a write of 1, only a real wrap sets it, never a special-event reset; set wins
		if (wrap && !special_reset && !count_write) begin
			overflow_flag_next = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// sequential state
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			control_reg <= stc3_pkg::stc3_control_t'(stc3_pkg::CONTROL_RESET);
		end else begin
			control_reg <= control_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count_reg <= stc3_pkg::COUNT_RESET;
		end else begin
			count_reg <= count_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			high_buffer_reg <= 8'h00;
		end else begin
			high_buffer_reg <= high_buffer_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			overflow_flag_reg <= 1'b0;
		end else begin
			overflow_flag_reg <= overflow_flag_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			overflow_irq_enable_reg <= 1'b0;
		end else begin
			overflow_irq_enable_reg <= overflow_irq_enable_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prescale_reg <= 3'h0;
		end else begin
			prescale_reg <= prescale_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync_pending_reg <= 1'b0;
		end else begin
			sync_pending_reg <= sync_pending_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			instr_phase_reg <= 2'h0;
		end else begin
			instr_phase_reg <= instr_phase_reg + 2'h1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ext_prev_reg <= 1'b0;
		end else begin
			ext_prev_reg <= ext_level;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			armed_reg <= 1'b0;
		end else begin
			// rearm after any control register write or while stopped
			armed_reg <= (wr_control || !run) ? 1'b0 : (armed_reg || ext_fall);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_read_reg <= 2'h0;
		end else begin
			pin_read_reg <= pin_read_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			adc_start_reg <= 1'b0;
		end else begin
			adc_start_reg <= adc_start_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			overflow_irq <= 1'b0;
		end else begin
			overflow_irq <= overflow_flag_next && overflow_irq_enable_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phase_reg <= '0;
			hrdata_reg <= 32'h0000_0000;
		end else begin
			phase_reg.valid <= addr_accept;
			phase_reg.write <= hwrite;
			phase_reg.addr <= addr_now;
			if (rd_now) begin
				hrdata_reg <= read_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign pin_read_value = pin_read_reg;
	assign adc_start = adc_start_reg;

endmodule : stc3_timer

//--- dv/stc3_timer_sva.sv
/*
 * port checker of the 16-bit timer/counter.
 * assumes bind into stc3_timer, one clock ref_clk, async reset rst.
 */
`timescale 1ns/100ps

module stc3_timer_sva (
	input logic ref_clk,
	input logic rst,
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [31:0] hwdata,
	input logic hready,
	input logic hreadyout,
	input logic hresp,
	input logic [31:0] hrdata,
	input logic low_freq_osc_enable,
	input logic [1:0] pin_read_value,
	input logic [3:0] first_capcomp_mode,
	input logic [3:0] second_capcomp_mode,
	input logic first_capcomp_match,
	input logic second_capcomp_match,
	input logic first_unit_uses_this_timer,
	input logic second_unit_uses_this_timer,
	input logic adc_enable,
	input logic adc_start,
	input logic overflow_irq
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	logic wr_reg;
	logic ctl_wr_reg;
	wire take = hsel && htrans[1] && hready;
	wire ev_one = first_capcomp_match && first_capcomp_mode == 4'hb
		&& first_unit_uses_this_timer;
	wire ev_two = second_capcomp_match && second_capcomp_mode == 4'hb
		&& second_unit_uses_this_timer;
	wire ev_ok = adc_enable && (ev_one || ev_two);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_reg <= 1'b0;
			ctl_wr_reg <= 1'b0;
		end else begin
			wr_reg <= take && hwrite;
			ctl_wr_reg <= take && hwrite && haddr[7:0] == stc3_pkg::ADDR_CONTROL;
		end
	end

	property p_ctl_map;
		ctl_wr_reg |=> first_unit_uses_this_timer == $past(hwdata[6])
			&& second_unit_uses_this_timer == $past(hwdata[6] | hwdata[3]);
	endproperty
	a_ctl_map: assert property (p_ctl_map) else $error("time base select wrong");
	property p_both;
		first_unit_uses_this_timer |-> second_unit_uses_this_timer;
	endproperty
	a_both: assert property (p_both) else $error("first unit without second");
	property p_pins;
		low_freq_osc_enable |=> pin_read_value == 2'h0;
	endproperty
	a_pins: assert property (p_pins) else $error("pins not read as zero");
	property p_adc_cause;
		adc_start |-> $past(ev_ok);
	endproperty
	a_adc_cause: assert property (p_adc_cause) else $error("conversion without event");
	property p_adc_effect;
		ev_ok |=> adc_start;
	endproperty
	a_adc_effect: assert property (p_adc_effect) else $error("conversion missing");
	property p_irq_hold;
		$fell(overflow_irq) |-> $past(wr_reg);
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("request dropped alone");
	property p_rdata;
		!(take && !hwrite) |=> $stable(hrdata) && hrdata[31:8] == 24'h0;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data moved");
	property p_bus_ok;
		hreadyout && !hresp;
	endproperty
	a_bus_ok: assert property (p_bus_ok) else $error("bus response wrong");
endmodule : stc3_timer_sva

//--- dv/stc3_clk_source.sv
/*
 * far side model: external count pin and low-frequency oscillator.
 * assumes the bench calls pulse; both lines idle low between bursts.
 */
`timescale 1ns/100ps

module stc3_clk_source (
	input logic ref_clk,
	output logic external_count_pin,
	output logic low_freq_osc_in
);
	initial begin
		{low_freq_osc_in, external_count_pin} = 2'b00;
	end

	// n rising edges on one source, each level held hold cycles
	task automatic pulse(input bit osc, input int n, input int hold);
		for (int i = 0; i < n; i++) begin
			repeat (hold) @(posedge ref_clk);
			{low_freq_osc_in, external_count_pin} <= osc ? 2'b10 : 2'b01;
			repeat (hold) @(posedge ref_clk);
			{low_freq_osc_in, external_count_pin} <= 2'b00;
		end
	endtask : pulse
endmodule : stc3_clk_source

//--- dv/stc3_timer_tb.sv
/*
 * self-checking bench of the 16-bit timer/counter over AHB-Lite.
 * assumes the package, design, clock source model and checker are compiled.
 */
`timescale 1ns/100ps

module stc3_timer_tb;
	localparam logic [7:0] CTL = stc3_pkg::ADDR_CONTROL;
	localparam logic [7:0] LO = stc3_pkg::ADDR_COUNT_LOW;
	localparam logic [7:0] HI = stc3_pkg::ADDR_COUNT_HIGH;
	localparam logic [7:0] FLG = stc3_pkg::ADDR_FLAGS;
	logic ref_clk, rst, hsel, hwrite, hreadyout, hresp, adc_enable, adc_start;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [1:0] htrans, pin_read_value;
	logic [2:0] hsize;
	logic external_count_pin, low_freq_osc_in, low_freq_osc_enable, overflow_irq;
	logic [3:0] first_capcomp_mode, second_capcomp_mode;
	logic first_capcomp_match, second_capcomp_match;
	logic first_unit_uses_this_timer, second_unit_uses_this_timer;
	int error_cnt = 0;
	int cmp_count = 0;

	stc3_timer i_stc3_timer (.hready(hreadyout), .*);
	stc3_clk_source i_stc3_clk_source (.*);

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// bus and compare
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: expected %h got %h", $time, exp, got);
		end
	endtask : chk
	task automatic chk_in(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
		cmp_count++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			error_cnt++;
			$display("Error at %0t: expected %h to %h got %h", $time, lo, hi, got);
		end
	endtask : chk_in
	// ev raises the second unit match during the data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input bit ev);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		if (ev) second_capcomp_match <= 1'b1;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rv = hrdata;
		if (ev) second_capcomp_match <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit ev = 1'b0);
		bus(1'b1, a, d, ev);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 1'b0);
		chk(exp, rv);
	endtask : rdc

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		rdc(CTL, {24'h0, stc3_pkg::CONTROL_RESET});
		rdc(LO, 32'h0);
		rdc(HI, 32'h0);
		rdc(FLG, 32'h0);
		rdc(stc3_pkg::ADDR_ENABLES, 32'h0);
		wr(8'h14, 32'hff);
		rdc(8'h14, stc3_pkg::READ_UNMAPPED);
		wr(CTL, 32'hfe);
		rdc(CTL, 32'hfe);
	endtask : t_regs
	task automatic t_timer;
		logic [31:0] n;
		for (int p = 0; p < 4; p++) begin
			wr(CTL, 32'h0);
			wr(HI, 32'h0);
			wr(LO, 32'h0);
			wr(CTL, {26'h0, 2'(p), p[0], 3'h1});
			repeat (254) @(posedge ref_clk);
			wr(CTL, 32'h0);
			bus(1'b0, LO, 32'h0, 1'b0);
			n = rv;
			chk_in(32'((64 >> p) - 1), 32'((64 >> p) + 1), n);
			repeat (20) @(posedge ref_clk);
			rdc(LO, n);
		end
	endtask : t_timer
	task automatic t_wide;
		wr(CTL, 32'h80);
		wr(HI, 32'hab);
		rdc(HI, 32'hab);
		wr(LO, 32'hcd);
		wr(CTL, 32'h0);
		rdc(LO, 32'hcd);
		rdc(HI, 32'hab);
		wr(HI, 32'h55);
		rdc(HI, 32'h55);
		wr(CTL, 32'h80);
		wr(HI, 32'h12);
		wr(CTL, 32'h0);
		rdc(HI, 32'h55);
		wr(CTL, 32'h80);
		rdc(LO, 32'hcd);
		rdc(HI, 32'h55);
	endtask : t_wide
	task automatic t_ovf;
		wr(CTL, 32'h0);
		wr(HI, 32'hff);
		wr(LO, 32'hfe);
		wr(CTL, 32'h1);
		repeat (20) @(posedge ref_clk);
		chk(32'h0, overflow_irq);
		rdc(FLG, 32'h1);
		wr(stc3_pkg::ADDR_ENABLES, 32'h1);
		@(negedge ref_clk);
		chk(32'h1, overflow_irq);
		@(posedge ref_clk);
		wr(FLG, 32'h0);
		@(negedge ref_clk);
		chk(32'h0, overflow_irq);
		@(posedge ref_clk);
		wr(CTL, 32'h0);
	endtask : t_ovf
	task automatic ev_try(input bit u, input bit hit, input bit adc);
		wr(LO, 32'h34);
		{second_capcomp_match, first_capcomp_match} <= u ? 2'b10 : 2'b01;
		@(posedge ref_clk);
		{second_capcomp_match, first_capcomp_match} <= 2'b00;
		@(negedge ref_clk);
		chk({31'h0, adc}, adc_start);
		@(posedge ref_clk);
		rdc(LO, hit ? 32'h0 : 32'h34);
	endtask : ev_try
	task automatic t_event;
		{first_capcomp_mode, second_capcomp_mode, adc_enable} <= {8'hbb, 1'b1};
		wr(HI, 32'hff);
		wr(CTL, 32'h08);
		ev_try(1'b1, 1'b1, 1'b1);
		rdc(HI, 32'h0);
		rdc(FLG, 32'h0);
		for (int c = 0; c < 3; c++) begin
			wr(CTL, c == 2 ? 32'h40 : (c == 1 ? 32'h08 : 32'h0));
			ev_try(1'b0, c == 2, c == 2);
			ev_try(1'b1, c != 0, c != 0);
		end
		adc_enable <= 1'b0;
		ev_try(1'b0, 1'b1, 1'b0);
		first_capcomp_mode <= 4'ha;
		ev_try(1'b0, 1'b0, 1'b0);
		wr(CTL, 32'h08);
		wr(LO, 32'h56, 1'b1);
		rdc(LO, 32'h56);
	endtask : t_event
	task automatic t_ext;
		for (int k = 0; k < 4; k++) begin
			low_freq_osc_enable <= k[1];
			wr(LO, 32'h0);
			wr(CTL, {29'h0, k[0], 2'h3});
			i_stc3_clk_source.pulse(k[1], 5, 6);
			repeat (12) @(posedge ref_clk);
			wr(CTL, 32'h0);
			rdc(LO, 32'h4);
		end
	endtask : t_ext

	task automatic conclude;
		$display("comparisons %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude

	initial begin
		rst = 1'b1;
		{hsel, hwrite, haddr, htrans, hwdata, hsize} = {36'h0, 32'h0, 3'h2};
		{low_freq_osc_enable, adc_enable, first_capcomp_match, second_capcomp_match} = 4'h0;
		{first_capcomp_mode, second_capcomp_mode} = 8'h0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_regs;
		t_timer;
		t_wide;
		t_ovf;
		t_event;
		t_ext;
		conclude;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		conclude;
	end
endmodule : stc3_timer_tb

bind stc3_timer stc3_timer_sva i_stc3_timer_sva (.*);
